// ===== design/rpx_pkg.sv
// Constants, field layouts and types shared by the remote point exchange block
package rpx_pkg;

  // ==========================================================================
  // Sizes
  localparam int NUM_VO       = 64;
  localparam int NUM_PEER     = 16;
  localparam int PEER_W       = 4;
  localparam int NUM_RIN      = 64;
  localparam int MSG_PAIRS    = 128;
  localparam int PREDEF_PAIRS = 32;
  localparam int USER_PAIRS   = 32;
  localparam int KEPT_BITS    = 2 * (PREDEF_PAIRS + USER_PAIRS);
  localparam int MSG_BITS     = 2 * MSG_PAIRS;
  localparam int ID_W         = 32;
  localparam int INT_W        = 16;
  localparam int HOLD_W       = 18;
  localparam int HOLD_MULT    = 3;
  localparam int ADR_W        = 9;

  // ==========================================================================
  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_NS       = 1000000;
  localparam int TICK_CYC      = TICK_NS / CLK_PERIOD_NS;

  // ==========================================================================
  // Register byte offsets
  localparam logic [ADR_W-1:0] REG_CTRL     = 9'h000;
  localparam logic [ADR_W-1:0] REG_INTERVAL = 9'h004;
  localparam logic [ADR_W-1:0] REG_LOCAL_ID = 9'h008;
  localparam logic [ADR_W-1:0] REG_COMM     = 9'h00C;
  localparam logic [ADR_W-1:0] REG_VO_ASG_L = 9'h010;
  localparam logic [ADR_W-1:0] REG_VO_ASG_H = 9'h014;
  localparam logic [ADR_W-1:0] REG_VO_EVT_L = 9'h018;
  localparam logic [ADR_W-1:0] REG_VO_EVT_H = 9'h01C;
  localparam logic [ADR_W-1:0] REG_VO_ST_L  = 9'h020;
  localparam logic [ADR_W-1:0] REG_VO_ST_H  = 9'h024;
  localparam logic [ADR_W-1:0] REG_RIN_L    = 9'h028;
  localparam logic [ADR_W-1:0] REG_RIN_H    = 9'h02C;
  localparam logic [ADR_W-1:0] REG_PEER_ID  = 9'h040;
  localparam logic [ADR_W-1:0] REG_RIN_CFG  = 9'h100;

  // ==========================================================================
  // Fields and reset values
  localparam int CTRL_TX_EN_BIT = 0;
  localparam int CFG_DEV_LSB    = 0;
  localparam int CFG_PAIR_LSB   = 4;
  localparam int CFG_PAIR_W     = 6;
  localparam int CFG_MODE_LSB   = 10;
  localparam int CFG_W          = 12;

  localparam logic [31:0]      CTRL_RST     = 32'h0000_0001;
  localparam logic [INT_W-1:0] INTERVAL_RST = 16'h03E8;
  // Arbitrary neutral originator name
  localparam logic [ID_W-1:0]  LOCAL_ID_RST = 32'h0000_0001;

  typedef enum logic [1:0] {FB_OFF, FB_ON, FB_LATEST_ON, FB_LATEST_OFF} rpx_fb_t;

  // Byte-lane merge for bus writes
  function automatic logic [31:0] rpx_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  sel);
    logic [31:0] m;
    m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    return (old_v & ~m) | (new_v & m);
  endfunction

endpackage

// ===== design/rpx_hold_if.sv
// Link between the core and one peer hold timer
`timescale 1ns/1ns
interface rpx_hold_if import rpx_pkg::*;;
  logic              load;
  logic [HOLD_W-1:0] hold;
  logic              tick;
  logic              online;

  modport ctl (output load, output hold, output tick, input online);
  modport tmr (input load, input hold, input tick, output online);
endinterface

// ===== design/rpx_hold_timer.sv
// Per-peer hold timer: reloads on each accepted message, drops online at expiry
`timescale 1ns/1ns
module rpx_hold_timer import rpx_pkg::*; (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  rpx_hold_if.tmr  hif
);

  logic [HOLD_W-1:0] cnt;
  logic              online;

  assign hif.online = online;

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt    <= '0;
      online <= 1'b0; // RULE_20
    end else if (hif.load) begin
      cnt    <= hif.hold; // RULE_08
      online <= 1'b1; // RULE_09
    end else if (hif.tick && online) begin
      if (cnt <= HOLD_W'(1)) begin
        cnt    <= '0;
        online <= 1'b0; // RULE_08
      end else begin
        cnt <= cnt - HOLD_W'(1);
      end
    end
  end

endmodule

// ===== design/rpx_top.sv
// Remote point exchange: virtual outputs, status message transmit and receive
//
// How it works
// (RULE_01) 64 virtual outputs; unassigned ones are forced to 0.
// (RULE_02) Outputs refresh each logic pass; enabled ones report every change.
// (RULE_03) Message holds 128 two-bit fields: 32 predefined then user pairs.
// (RULE_04) Only 32 of the 96 user pairs are carried and kept.
// (RULE_05) Send at power-up, on any point change, or when the interval lapses.
// (RULE_06) Each message carries hold time of three times the update interval.
// (RULE_07) Accept only messages whose originator matches a selected peer.
// (RULE_08) Message loads peer hold timer; expiry marks peer offline, fallbacks apply.
// (RULE_09) Timely message updates all peer points and restarts its timer.
// (RULE_10) Per-peer communication status is readable; 0 means offline.
// (RULE_11) 64 remote inputs and 64 remote outputs are supported.
// (RULE_12) Sixteen peer entries, each holding the exact identifier to match.
// (RULE_13) Transmitted originator comes from the local name register.
// (RULE_14) Each remote input picks one of 64 sources: 32 predefined, 32 user.
// (RULE_15) Device number picks the peer, pair select picks the bit pair.
// (RULE_16) Fallback applies after startup and while offline; on=1, off=0.
// (RULE_17) Latest/on holds last value, 1 if none yet, follows on resume.
// (RULE_18) Latest/off holds last value, 0 if none yet, follows on resume.
// (RULE_19) Programmable update interval paces messages while nothing changes.
// (RULE_20) Every peer starts offline and goes online only on a matching message.
//
// Implementation choices: the address map and register access over Wishbone.
`timescale 1ns/1ns
module rpx_top import rpx_pkg::*; #(
  parameter int TICK_CYCLES = TICK_CYC
) (
  input  wire logic                 core_clk_i,
  input  wire logic                 nrst_i,
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [ADR_W-1:0]     wb_adr_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic [31:0]          wb_dat_i,
  output logic      [31:0]          wb_dat_o,
  output logic                      wb_ack_o,
  input  wire logic                 eval_pass_i,
  input  wire logic [NUM_VO-1:0]    logic_eq_i,
  output logic      [NUM_VO-1:0]    vo_o,
  output logic                      vo_event_o,
  output logic      [NUM_VO-1:0]    vo_event_bits_o,
  input  wire logic [KEPT_BITS-1:0] tx_src_i,
  output logic                      tx_valid_o,
  output logic      [ID_W-1:0]      tx_id_o,
  output logic      [HOLD_W-1:0]    tx_hold_o,
  output logic      [MSG_BITS-1:0]  tx_pairs_o,
  input  wire logic                 rx_valid_i,
  input  wire logic [ID_W-1:0]      rx_id_i,
  input  wire logic [HOLD_W-1:0]    rx_hold_i,
  input  wire logic [MSG_BITS-1:0]  rx_pairs_i,
  output logic      [NUM_RIN-1:0]   rin_o,
  output logic      [NUM_PEER-1:0]  peer_online_o
);

  // ==========================================================================
  // Register state
  logic [31:0]       ctrl;
  logic [INT_W-1:0]  interval;
  logic [ID_W-1:0]   local_id;
  logic [NUM_VO-1:0] vo_assign;
  logic [NUM_VO-1:0] vo_evt_en;
  logic [ID_W-1:0]   peer_id  [NUM_PEER];
  logic [CFG_W-1:0]  rin_cfg  [NUM_RIN];

  // ==========================================================================
  // Wishbone decode
  logic       req;
  logic       wr;
  logic [4:0] word_lo;
  logic [3:0] peer_idx;
  logic [5:0] cfg_idx;
  logic       hit_peer;
  logic       hit_cfg;
  logic [31:0] rd_fixed;
  logic [31:0] rd_word;

  assign req      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr       = req & wb_we_i;
  assign word_lo  = wb_adr_i[6:2];
  assign peer_idx = wb_adr_i[5:2];
  assign cfg_idx  = wb_adr_i[7:2];
  assign hit_peer = (wb_adr_i[ADR_W-1:6] == REG_PEER_ID[ADR_W-1:6]);
  assign hit_cfg  = (wb_adr_i[ADR_W-1:8] == REG_RIN_CFG[ADR_W-1:8]);

  assign rd_fixed =
      (wb_adr_i == REG_CTRL)     ? ctrl :
      (wb_adr_i == REG_INTERVAL) ? {16'h0000, interval} :
      (wb_adr_i == REG_LOCAL_ID) ? local_id :
      (wb_adr_i == REG_COMM)     ? {16'h0000, peer_online_o} : // RULE_10
      (wb_adr_i == REG_VO_ASG_L) ? vo_assign[31:0] :
      (wb_adr_i == REG_VO_ASG_H) ? vo_assign[63:32] :
      (wb_adr_i == REG_VO_EVT_L) ? vo_evt_en[31:0] :
      (wb_adr_i == REG_VO_EVT_H) ? vo_evt_en[63:32] :
      (wb_adr_i == REG_VO_ST_L)  ? vo_o[31:0] :
      (wb_adr_i == REG_VO_ST_H)  ? vo_o[63:32] :
      (wb_adr_i == REG_RIN_L)    ? rin_o[31:0] :
      (wb_adr_i == REG_RIN_H)    ? rin_o[63:32] : 32'h0000_0000;

  assign rd_word = hit_peer ? peer_id[peer_idx] :
                   hit_cfg  ? {20'h00000, rin_cfg[cfg_idx]} : rd_fixed;

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= req ? rd_word : 32'h0000_0000;
    end
  end

  // ==========================================================================
  // Register writes
  logic [31:0] wr_merged;

  assign wr_merged = rpx_merge(rd_word, wb_dat_i, wb_sel_i);

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctrl      <= CTRL_RST;
      interval  <= INTERVAL_RST;
      local_id  <= LOCAL_ID_RST;
      vo_assign <= '0;
      vo_evt_en <= '0;
      for (int i = 0; i < NUM_PEER; i++) begin
        peer_id[i] <= '0;
      end
      for (int i = 0; i < NUM_RIN; i++) begin
        rin_cfg[i] <= '0;
      end
    end else if (wr) begin
      if (hit_peer) begin
        peer_id[peer_idx] <= wr_merged; // RULE_12
      end else if (hit_cfg) begin
        rin_cfg[cfg_idx] <= wr_merged[CFG_W-1:0]; // RULE_15
      end else begin
        unique case (wb_adr_i)
          REG_CTRL:     ctrl <= {31'h0, wr_merged[CTRL_TX_EN_BIT]};
          REG_INTERVAL: interval <= wr_merged[INT_W-1:0]; // RULE_19
          REG_LOCAL_ID: local_id <= wr_merged;
          REG_VO_ASG_L: vo_assign[31:0] <= wr_merged;
          REG_VO_ASG_H: vo_assign[63:32] <= wr_merged;
          REG_VO_EVT_L: vo_evt_en[31:0] <= wr_merged;
          REG_VO_EVT_H: vo_evt_en[63:32] <= wr_merged;
          default: ;
        endcase
      end
    end
  end

  // ==========================================================================
  // Virtual outputs
  logic [NUM_VO-1:0] next_vo;
  logic [NUM_VO-1:0] vo_changed;

  assign next_vo    = logic_eq_i & vo_assign; // RULE_01
  assign vo_changed = (next_vo ^ vo_o) & vo_evt_en;

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      vo_o            <= '0;
      vo_event_o      <= 1'b0;
      vo_event_bits_o <= '0;
    end else begin
      vo_event_o      <= eval_pass_i & (|vo_changed); // RULE_02
      vo_event_bits_o <= eval_pass_i ? vo_changed : '0;
      if (eval_pass_i) begin
        vo_o <= next_vo; // RULE_02
      end
    end
  end

  // ==========================================================================
  // Millisecond tick
  logic [31:0] div_cnt;
  logic        ms_tick;

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      div_cnt <= 32'h0000_0000;
      ms_tick <= 1'b0;
    end else if (div_cnt >= 32'(TICK_CYCLES - 1)) begin
      div_cnt <= 32'h0000_0000;
      ms_tick <= 1'b1;
    end else begin
      div_cnt <= div_cnt + 32'h0000_0001;
      ms_tick <= 1'b0;
    end
  end

  // ==========================================================================
  // Transmitter
  logic [KEPT_BITS-1:0] tx_prev;
  logic                 pwrup;
  logic [INT_W-1:0]     int_cnt;
  logic                 src_changed;
  logic                 interval_due;
  logic                 send;
  logic [HOLD_W-1:0]    next_hold;

  assign src_changed  = (tx_src_i != tx_prev);
  assign interval_due = ms_tick && ({1'b0, int_cnt} + 17'h00001 >= {1'b0, interval}); // RULE_19
  assign send         = ctrl[CTRL_TX_EN_BIT] & (pwrup | src_changed | interval_due); // RULE_05
  assign next_hold    = HOLD_W'(interval) * HOLD_W'(HOLD_MULT); // RULE_06

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tx_prev    <= '0;
      pwrup      <= 1'b1;
      int_cnt    <= '0;
      tx_valid_o <= 1'b0;
      tx_id_o    <= '0;
      tx_hold_o  <= '0;
      tx_pairs_o <= '0;
    end else begin
      tx_valid_o <= send;
      if (send) begin
        tx_prev    <= tx_src_i;
        pwrup      <= 1'b0;
        int_cnt    <= '0;
        tx_id_o    <= local_id; // RULE_13
        tx_hold_o  <= next_hold; // RULE_06
        tx_pairs_o <= {{(MSG_BITS - KEPT_BITS){1'b0}}, tx_src_i}; // RULE_03 RULE_04
      end else if (ms_tick) begin
        int_cnt <= int_cnt + INT_W'(1);
      end
    end
  end

  // ==========================================================================
  // Receiver: peer match, stored pairs and hold timers
  logic [NUM_PEER-1:0]  peer_hit;
  logic [KEPT_BITS-1:0] rx_mem [NUM_PEER];
  rpx_hold_if           hif [NUM_PEER] ();

  for (genvar g = 0; g < NUM_PEER; g++) begin : g_peer
    assign peer_hit[g] = rx_valid_i && (peer_id[g] != '0) && (peer_id[g] == rx_id_i); // RULE_07
    assign hif[g].load = peer_hit[g]; // RULE_08
    assign hif[g].hold = rx_hold_i;
    assign hif[g].tick = ms_tick;
    assign peer_online_o[g] = hif[g].online; // RULE_10

    rpx_hold_timer u_hold (
      .core_clk_i (core_clk_i),
      .nrst_i     (nrst_i),
      .hif        (hif[g])
    );
  end

  // Contents are don't-care until the peer first goes online
  always_ff @(posedge core_clk_i) begin
    for (int i = 0; i < NUM_PEER; i++) begin
      if (peer_hit[i]) begin
        rx_mem[i] <= rx_pairs_i[KEPT_BITS-1:0]; // RULE_09 RULE_04
      end
    end
  end

  // ==========================================================================
  // Remote inputs
  logic [NUM_RIN-1:0] src_bit;
  logic [NUM_RIN-1:0] src_on;
  logic [NUM_RIN-1:0] last_val;
  logic [NUM_RIN-1:0] known;

  for (genvar k = 0; k < NUM_RIN; k++) begin : g_rin
    logic [PEER_W-1:0]     dev;
    logic [CFG_PAIR_W-1:0] pair;
    assign dev        = rin_cfg[k][CFG_DEV_LSB +: PEER_W]; // RULE_15
    assign pair       = rin_cfg[k][CFG_PAIR_LSB +: CFG_PAIR_W]; // RULE_14
    assign src_bit[k] = rx_mem[dev][{pair, 1'b1}];
    assign src_on[k]  = peer_online_o[dev];
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rin_o    <= '0;
      last_val <= '0;
      known    <= '0;
    end else begin
      for (int k = 0; k < NUM_RIN; k++) begin // RULE_11
        if (src_on[k]) begin
          rin_o[k]    <= src_bit[k]; // RULE_09
          last_val[k] <= src_bit[k];
          known[k]    <= 1'b1;
        end else begin
          unique case (rpx_fb_t'(rin_cfg[k][CFG_MODE_LSB +: 2]))
            FB_OFF:        rin_o[k] <= 1'b0; // RULE_16
            FB_ON:         rin_o[k] <= 1'b1; // RULE_16
            FB_LATEST_ON:  rin_o[k] <= known[k] ? last_val[k] : 1'b1; // RULE_17
            FB_LATEST_OFF: rin_o[k] <= known[k] ? last_val[k] : 1'b0; // RULE_18
          endcase
        end
      end
    end
  end

endmodule

// ===== verif/rpx_checker.sv
// Port-level assertions for the remote point exchange top
`timescale 1ns/1ns
module rpx_checker import rpx_pkg::*; #(
  parameter int TICK_CYCLES = TICK_CYC
) (
  input wire logic                 core_clk_i,
  input wire logic                 nrst_i,
  input wire logic                 wb_cyc_i,
  input wire logic                 wb_stb_i,
  input wire logic [31:0]          wb_dat_o,
  input wire logic                 wb_ack_o,
  input wire logic                 eval_pass_i,
  input wire logic [NUM_VO-1:0]    vo_o,
  input wire logic                 vo_event_o,
  input wire logic [NUM_VO-1:0]    vo_event_bits_o,
  input wire logic [KEPT_BITS-1:0] tx_src_i,
  input wire logic                 tx_valid_o,
  input wire logic [MSG_BITS-1:0]  tx_pairs_o,
  input wire logic                 rx_valid_i,
  input wire logic [NUM_PEER-1:0]  peer_online_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);
  // ==========================================================================
  // Bus handshake
  sequence wb_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence wb_ans;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  bus_ack_a: assert property (wb_req |=> wb_ans)
    else $error("bus request not answered by one ack");
  dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  // ==========================================================================
  // Virtual outputs
  vo_hold_a: assert property (!eval_pass_i |=> $stable(vo_o))
    else $error("virtual outputs moved without a pass");
  evt_cause_a: assert property (vo_event_o |-> $past(eval_pass_i))
    else $error("event without a pass");
  evt_bits_a: assert property ((vo_event_bits_o & ~(vo_o ^ $past(vo_o))) == '0
    && (vo_event_o || vo_event_bits_o == '0)) else $error("event bits wrong");
  // ==========================================================================
  // Transmit and receive
  tx_data_a: assert property (tx_valid_o |->
    tx_pairs_o == {{(MSG_BITS-KEPT_BITS){1'b0}}, $past(tx_src_i)}) else $error("sent fields wrong");
  tx_keep_a: assert property (!tx_valid_o |-> $stable(tx_pairs_o))
    else $error("sent fields changed between messages");
  tx_once_a: assert property (tx_valid_o && tx_pairs_o[KEPT_BITS-1:0] == tx_src_i
    |=> !tx_valid_o) else $error("repeat send without cause");
  peer_up_a: assert property ((peer_online_o & ~$past(peer_online_o)) != '0
    |-> $past(rx_valid_i)) else $error("peer online without a message");
endmodule
bind rpx_top rpx_checker #(.TICK_CYCLES(TICK_CYCLES)) chk (
  .core_clk_i(core_clk_i), .nrst_i(nrst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .eval_pass_i(eval_pass_i), .vo_o(vo_o),
  .vo_event_o(vo_event_o), .vo_event_bits_o(vo_event_bits_o), .tx_src_i(tx_src_i),
  .tx_valid_o(tx_valid_o), .tx_pairs_o(tx_pairs_o), .rx_valid_i(rx_valid_i),
  .peer_online_o(peer_online_o)
);

// ===== verif/rpx_peer.sv
// Peer relay model: one status message on the receive port per request
`timescale 1ns/1ns
module rpx_peer import rpx_pkg::*; (
  input  wire logic                core_clk_i,
  input  wire logic                send_i,
  input  wire logic [ID_W-1:0]     id_i,
  input  wire logic [HOLD_W-1:0]   hold_i,
  input  wire logic [MSG_BITS-1:0] pairs_i,
  output logic                     rx_valid_o,
  output logic      [ID_W-1:0]     rx_id_o,
  output logic      [HOLD_W-1:0]   rx_hold_o,
  output logic      [MSG_BITS-1:0] rx_pairs_o
);
  // Between messages the fields show the inverse of the id, hold and pairs inputs sampled at the last clock edge
  always @(posedge core_clk_i) begin
    rx_valid_o <= send_i;
    rx_id_o <= send_i ? id_i : ~id_i;
    rx_hold_o <= send_i ? hold_i : ~hold_i;
    rx_pairs_o <= send_i ? pairs_i : ~pairs_i;
  end
endmodule

// ===== verif/tb.sv
// Self-checking bench for the remote point exchange block
`timescale 1ns/1ns
module tb import rpx_pkg::*;;
  localparam int TC = 10;
  logic clk, nrst, cyc, stb, we, ack, eval, txv, rxv, vev, snd;
  logic [ADR_W-1:0] adr;
  logic [31:0] dat, dat_o, id, pid, q, expq[$];
  logic [63:0] eq, vob, vevb, rin, a, e;
  logic [127:0] txs, p;
  logic [255:0] txp, rxp, sp;
  logic [ID_W-1:0] txid, rxid, sid;
  logic [HOLD_W-1:0] txh, rxh, sh;
  logic [15:0] onl, seed;
  logic [5:0] src[4];
  int n_errors, checks_done, cycles, ntx, n, i;
  rpx_top #(.TICK_CYCLES(TC)) dut (.core_clk_i(clk), .nrst_i(nrst), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .eval_pass_i(eval), .logic_eq_i(eq), .vo_o(vob),
    .vo_event_o(vev), .vo_event_bits_o(vevb), .tx_src_i(txs), .tx_valid_o(txv),
    .tx_id_o(txid), .tx_hold_o(txh), .tx_pairs_o(txp), .rx_valid_i(rxv), .rx_id_i(rxid),
    .rx_hold_i(rxh), .rx_pairs_i(rxp), .rin_o(rin), .peer_online_o(onl));
  rpx_peer peer (.core_clk_i(clk), .send_i(snd), .id_i(sid), .hold_i(sh), .pairs_i(sp),
    .rx_valid_o(rxv), .rx_id_o(rxid), .rx_hold_o(rxh), .rx_pairs_o(rxp));
  // ==========================================================================
  // Helpers
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [31:0] rnd();
    logic [15:0] h;
    h = lfsr(seed);
    seed = lfsr(h);
    return {h, seed};
  endfunction
  function automatic logic [31:0] pick(input logic [127:0] v);
    logic [31:0] r;
    r = 32'h0;
    for (int k = 0; k < 4; k++) r[k] = v[2 * src[k] + 1];
    return r;
  endfunction
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wb(input logic [ADR_W-1:0] ad, input logic w, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= ad;
    dat <= d;
    @(posedge clk);
    while (ack !== 1'b1) @(posedge clk);
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [ADR_W-1:0] ad, input logic [31:0] exp);
    expq.push_back(exp);
    wb(ad, 1'b0, 32'h0);
  endtask
  task automatic wait_tx(output int c);
    c = 0;
    do begin
      @(posedge clk);
      c++;
    end while (txv !== 1'b1);
  endtask
  task automatic msg(input logic [31:0] m, input logic [127:0] v);
    sid <= m;
    sh <= 18'h5;
    sp <= {128'h0, v};
    snd <= 1'b1;
    @(posedge clk);
    snd <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ==========================================================================
  // Clock, watchers and timeout
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) if (ack === 1'b1 && we === 1'b0) chk(dat_o, expq.pop_front());
  always @(posedge clk) begin
    cycles++;
    if (txv === 1'b1) ntx++;
    if (cycles == 6000) begin
      n_errors++;
      conclude();
    end
  end
  // ==========================================================================
  // Main sequence
  initial begin
    {nrst, cyc, stb, we, eval, snd} = '0;
    {adr, dat, eq, sid, sh, sp} = '0;
    seed = 16'hC91B;
    src = '{6'h00, 6'h21, 6'h05, 6'h3F};
    txs = {rnd(), rnd(), rnd(), rnd()};
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    wait_tx(n);
    chk(n, 2);
    chk(txid, LOCAL_ID_RST);
    chk(txh, 3 * INTERVAL_RST);
    rd(REG_CTRL, CTRL_RST);
    rd(REG_INTERVAL, 32'(INTERVAL_RST));
    rd(REG_COMM, 32'h0);
    wb(9'h0F0, 1'b1, 32'hFFFF_FFFF);
    rd(9'h0F0, 32'h0);
    id = rnd();
    wb(REG_LOCAL_ID, 1'b1, id);
    wb(REG_INTERVAL, 1'b1, 32'h4);
    txs <= {rnd(), rnd(), rnd(), rnd()};
    wait_tx(n);
    chk(txid, id);
    chk(txh, 18'hC);
    repeat (3) wait_tx(n);
    chk(n, 4 * TC);
    wb(REG_CTRL, 1'b1, 32'h0);
    i = ntx;
    txs <= ~txs;
    repeat (60) @(posedge clk);
    chk(ntx - i, 0);
    wb(REG_CTRL, 1'b1, 32'h1);
    @(posedge clk);
    chk(ntx - i, 1);
    chk(txp[63:0], txs[63:0]);
    a = {rnd(), rnd()};
    e = {rnd(), rnd()};
    wb(REG_VO_ASG_L, 1'b1, a[31:0]);
    wb(REG_VO_ASG_H, 1'b1, a[63:32]);
    wb(REG_VO_EVT_L, 1'b1, 32'hFFFF_FFFF);
    for (i = 0; i < 2; i++) begin
      eq <= e;
      eval <= 1'b1;
      @(posedge clk);
      eval <= 1'b0;
      eq <= ~e;
      @(posedge clk);
      chk(vevb, (e ^ (i ? ~e : 64'h0)) & a & 64'h0000_0000_FFFF_FFFF);
      rd(REG_VO_ST_L, e[31:0] & a[31:0]);
      rd(REG_VO_ST_H, e[63:32] & a[63:32]);
      e = ~e;
    end
    pid = rnd() | 32'h1;
    wb(REG_PEER_ID + 9'h8, 1'b1, pid);
    for (i = 0; i < 4; i++) wb(REG_RIN_CFG + 9'(4 * i), 1'b1, {20'h0, i[1:0], src[i], 4'h2});
    rd(REG_RIN_L, 32'h6);
    rd(REG_RIN_H, 32'h0);
    msg(pid ^ 32'h80, '1);
    rd(REG_COMM, 32'h0);
    p = {rnd(), rnd(), rnd(), rnd()};
    msg(pid, p);
    rd(REG_COMM, 32'h4);
    rd(REG_RIN_L, pick(p));
    msg(pid, ~p);
    rd(REG_RIN_L, pick(~p));
    q = pick(~p);
    repeat (6 * TC) @(posedge clk);
    rd(REG_COMM, 32'h0);
    rd(REG_RIN_L, {28'h0, q[3:2], 2'h2});
    msg(pid, p);
    rd(REG_RIN_L, pick(p));
    repeat (2) @(posedge clk);
    conclude();
  end
endmodule
